// ==== rtl/icpac_config_port.sv ====
// Serial configuration slave, control pin modes and APB control of the clock generator.
`timescale 1ns/10ps
`default_nettype none
module icpac_config_port (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_pin,
  input wire logic sda_pin_i,
  output logic sda_pin_o,
  output logic sda_pin_oe,
  input wire logic clock3_or_select_pin,
  input wire logic aux_ref_or_restart_pin,
  input wire logic power_down_or_gate_pin,
  input wire logic clock6_or_spread_toggle_pin,
  output logic [7:0] out_enable,
  output logic out_hold_low,
  output logic pll_off,
  output logic spread_on,
  output logic clk3_drive_en,
  output logic clk6_drive_en,
  output logic [15:0] drive_strength,
  output logic set_sel,
  output logic [63:0] div_value,
  output logic div_load,
  output logic pll_relock
);
  import icpac_pkg::*;

  function automatic logic [7:0] next_ptr(input logic [7:0] p);
    next_ptr = p + 8'h01;
  endfunction

  function automatic logic [7:0] set_base(input logic sel);
    set_base = sel ? CFG_SET1_BASE : CFG_SET0_BASE;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [5:0] sync1_reg, sync2_reg;
  logic scl_d_reg, sda_d_reg;
  logic scl_s, sda_s, fs_s, rst_s, pd_s, spread_toggle_input_s;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 6'h32;
      sync2_reg <= 6'h32;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      sync1_reg <= {scl_pin, sda_pin_i, clock3_or_select_pin, aux_ref_or_restart_pin,
                    power_down_or_gate_pin, clock6_or_spread_toggle_pin};
      sync2_reg <= sync1_reg;
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end
  assign {scl_s, sda_s, fs_s, rst_s, pd_s, spread_toggle_input_s} = sync2_reg;

  logic scl_rise, scl_fall, start_det, stop_det;
  assign scl_rise = scl_s & ~scl_d_reg;
  assign scl_fall = ~scl_s & scl_d_reg;
  assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_det = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  // ----------------------------------------------------------------
  // APB control and status
  // ----------------------------------------------------------------
  logic [7:0] ctrl_reg;
  logic [31:0] prdata_reg;
  logic [7:0] ptr_reg;
  logic pd_act, rst_act, por_hit, cfg_clear, hold_act;
  icpac_state_e state_reg;
  logic addr_hit;
  assign addr_hit = (paddr == APB_CTRL_OFF) || (paddr == APB_STAT_OFF);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_hit;
  assign prdata = prdata_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= CTRL_RESET;
    end else if (psel && penable && pwrite && paddr == APB_CTRL_OFF) begin
      ctrl_reg <= pwdata[7:0];
    end
  end

  // Read data is captured in the setup phase so the access phase answers at once.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0;
    end else if (psel && !penable) begin
      if (paddr == APB_CTRL_OFF) begin
        prdata_reg <= {24'h0, ctrl_reg};
      end else if (paddr == APB_STAT_OFF) begin
        prdata_reg <= {20'h0, state_reg != ST_IDLE, hold_act, pd_act, set_sel, ptr_reg};
      end else begin
        prdata_reg <= 32'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control pin modes
  // ----------------------------------------------------------------
  assign rst_act = ctrl_reg[CTRL_RST_EN] & rst_s;
  assign por_hit = rst_act & ~ctrl_reg[CTRL_RST_CLEAN];
  assign hold_act = rst_act;
  assign pd_act = ctrl_reg[CTRL_PD_EN] & ~pd_s;
  // Without keep-alive, power-down returns the written bytes to their defaults, and they stay at the defaults after it ends.
  assign cfg_clear = por_hit | (pd_act & ~ctrl_reg[CTRL_KEEP]);

  // ----------------------------------------------------------------
  // Configuration bytes
  // ----------------------------------------------------------------
  logic [7:0] mem [256];
  logic [7:0] shift_reg;
  logic [3:0] bit_cnt_reg;
  logic first_reg, rw_reg, mack_reg, sda_oe_reg;
  logic wr_stb;
  assign wr_stb = state_reg == ST_RX && scl_fall && bit_cnt_reg == BITS_PER_BYTE && !first_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 256; i++) begin
        mem[i] <= REG_DEFAULT;
      end
    end else if (cfg_clear) begin
      for (int i = 0; i < 256; i++) begin
        mem[i] <= REG_DEFAULT;
      end
    end else if (wr_stb) begin
      mem[ptr_reg] <= shift_reg;
    end
  end

  // ----------------------------------------------------------------
  // Serial slave state machine
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      rw_reg <= 1'b0;
      first_reg <= 1'b0;
      mack_reg <= 1'b0;
      ptr_reg <= 8'h00;
      sda_oe_reg <= 1'b0;
    end else if (start_det) begin
      state_reg <= ST_ADDR;
      bit_cnt_reg <= 4'h0;
      sda_oe_reg <= 1'b0;
    end else if (stop_det) begin
      state_reg <= ST_IDLE;
      sda_oe_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          sda_oe_reg <= 1'b0;
        end
        ST_ADDR: begin
          if (scl_rise) begin
            shift_reg <= {shift_reg[6:0], sda_s};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall && bit_cnt_reg == BITS_PER_BYTE) begin
            if (shift_reg[7:1] == BUS_SLAVE_ID) begin
              state_reg <= ST_AACK;
              sda_oe_reg <= 1'b1;
              rw_reg <= shift_reg[0];
              first_reg <= 1'b1;
            end else begin
              state_reg <= ST_IDLE;
            end
          end
        end
        ST_AACK: begin
          if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            if (rw_reg) begin
              state_reg <= ST_TX;
              shift_reg <= mem[ptr_reg];
              ptr_reg <= next_ptr(ptr_reg);
              sda_oe_reg <= ~mem[ptr_reg][7];
            end else begin
              state_reg <= ST_RX;
              sda_oe_reg <= 1'b0;
            end
          end
        end
        ST_RX: begin
          if (scl_rise) begin
            shift_reg <= {shift_reg[6:0], sda_s};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall && bit_cnt_reg == BITS_PER_BYTE) begin
            state_reg <= ST_WACK;
            sda_oe_reg <= 1'b1;
            first_reg <= 1'b0;
            if (first_reg) begin
              ptr_reg <= shift_reg;
            end else begin
              ptr_reg <= next_ptr(ptr_reg);
            end
          end
        end
        ST_WACK: begin
          if (scl_fall) begin
            state_reg <= ST_RX;
            bit_cnt_reg <= 4'h0;
            sda_oe_reg <= 1'b0;
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_reg == TX_LAST_BIT) begin
              state_reg <= ST_MACK;
              sda_oe_reg <= 1'b0;
            end else begin
              shift_reg <= {shift_reg[6:0], 1'b0};
              sda_oe_reg <= ~shift_reg[6];
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            mack_reg <= ~sda_s;
          end else if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            if (mack_reg) begin
              state_reg <= ST_TX;
              shift_reg <= mem[ptr_reg];
              ptr_reg <= next_ptr(ptr_reg);
              sda_oe_reg <= ~mem[ptr_reg][7];
            end else begin
              state_reg <= ST_IDLE;
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          sda_oe_reg <= 1'b0;
        end
      endcase
    end
  end
  assign sda_pin_o = 1'b0;
  assign sda_pin_oe = sda_oe_reg;

  // ----------------------------------------------------------------
  // Output control
  // ----------------------------------------------------------------
  logic [7:0] out_en_reg;
  logic hold_reg, pll_off_reg, spread_reg, set_reg, set_prev_reg, load_reg, relock_reg;
  logic [15:0] drive_reg;
  logic [63:0] div_reg;
  logic set_next;
  logic [7:0] mf_mask;
  logic pll_differs;
  assign set_next = ctrl_reg[CTRL_CLK3_SEL] & fs_s;
  assign mf_mask = {2'h3, ~ctrl_reg[CTRL_CLK6_SPREAD], 2'h3, ~ctrl_reg[CTRL_CLK3_SEL], 2'h3};

  always_comb begin
    pll_differs = 1'b0;
    for (int i = 0; i < SET_PLL_BYTES; i++) begin
      if (mem[CFG_SET0_BASE + SET_PLL_OFS + 8'(i)]
          != mem[CFG_SET1_BASE + SET_PLL_OFS + 8'(i)]) begin
        pll_differs = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_en_reg <= 8'h00;
      hold_reg <= 1'b0;
      pll_off_reg <= 1'b0;
    end else begin
      hold_reg <= hold_act;
      pll_off_reg <= pd_act;
      if (hold_act || pd_act) begin
        out_en_reg <= 8'h00;
      end else if (ctrl_reg[CTRL_GATE_EN] && !ctrl_reg[CTRL_PD_EN]) begin
        out_en_reg <= mf_mask & (~mem[CFG_GATE_MASK] | {8{pd_s}});
      end else begin
        out_en_reg <= mf_mask;
      end
    end
  end

  // The load strobe comes with the new divider values, one cycle after the set switch.
  // The switch is clean only when the PLL bytes of both sets agree.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      set_reg <= 1'b0;
      set_prev_reg <= 1'b0;
      load_reg <= 1'b0;
      relock_reg <= 1'b0;
      div_reg <= 64'h0;
      drive_reg <= 16'h0;
      spread_reg <= 1'b0;
    end else begin
      set_reg <= set_next;
      set_prev_reg <= set_reg;
      load_reg <= set_reg != set_prev_reg;
      relock_reg <= (set_reg != set_prev_reg) && pll_differs;
      for (int i = 0; i < OUT_COUNT; i++) begin
        div_reg[8*i +: 8] <= mem[set_base(set_reg) + SET_DIV_OFS + 8'(i)];
      end
      drive_reg <= {mem[CFG_DRIVE_HI], mem[CFG_DRIVE_LO]};
      spread_reg <= ctrl_reg[CTRL_CLK6_SPREAD] ? spread_toggle_input_s : mem[CFG_SPREAD][0];
    end
  end

  assign out_enable = out_en_reg;
  assign out_hold_low = hold_reg;
  assign pll_off = pll_off_reg;
  assign spread_on = spread_reg;
  assign clk3_drive_en = ~ctrl_reg[CTRL_CLK3_SEL];
  assign clk6_drive_en = ~ctrl_reg[CTRL_CLK6_SPREAD];
  assign drive_strength = drive_reg;
  assign set_sel = set_reg;
  assign div_value = div_reg;
  assign div_load = load_reg;
  assign pll_relock = relock_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_write_ack: assert property (state_reg == ST_WACK |-> sda_oe_reg)
    else $error("write byte not acknowledged");
  chk_idle_quiet: assert property (state_reg == ST_IDLE |=> !sda_oe_reg)
    else $error("data line driven while idle");
  chk_ptr_wrap: assert property (wr_stb && ptr_reg == 8'hff |=> ptr_reg == 8'h00)
    else $error("pointer did not wrap");
  chk_por_clear: assert property (por_hit |=> mem[CFG_GATE_MASK] == REG_DEFAULT)
    else $error("reset did not restore defaults");
  chk_clean_hold: assert property (hold_act |=> out_hold_low && out_enable == 8'h00)
    else $error("clean start did not hold outputs");
  chk_pd_off: assert property (pd_act |=> pll_off && out_enable == 8'h00)
    else $error("power-down left outputs on");
  chk_gate_mask: assert property (ctrl_reg[CTRL_GATE_EN] && !ctrl_reg[CTRL_PD_EN]
    && !pd_s && !hold_act |=> (out_enable & $past(mem[CFG_GATE_MASK])) == 8'h00)
    else $error("gated output stayed on");
  chk_set_follow: assert property (ctrl_reg[CTRL_CLK3_SEL] && $changed(fs_s)
    |=> set_sel == $past(fs_s) ##1 div_load)
    else $error("set select not followed");
  chk_start_addr: assert property (start_det |=> state_reg == ST_ADDR)
    else $error("start not detected");
  chk_sda_low: assert property ($changed(sda_oe_reg) |-> !$past(scl_s)
    || $past(start_det) || $past(stop_det))
    else $error("data changed while clock high");

  cov_write: cover property (wr_stb);
  cov_read: cover property (state_reg == ST_AACK && rw_reg ##[1:40] state_reg == ST_TX);
  cov_seq_read: cover property (state_reg == ST_MACK && scl_fall && mack_reg);
  cov_foreign: cover property (state_reg == ST_ADDR ##1 state_reg == ST_IDLE);
endmodule // icpac_config_port
`default_nettype wire

// ==== rtl/icpac_pkg.sv ====
// Constants and types shared by the serial configuration port and control block.
package icpac_pkg;
  // ----------------------------------------------------------------
  // Serial port
  // ----------------------------------------------------------------
  localparam logic [6:0] BUS_SLAVE_ID = 7'h69;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] TX_LAST_BIT = 4'h7;
  localparam logic [7:0] REG_DEFAULT = 8'h00;
  // ----------------------------------------------------------------
  // Configuration byte map behind the serial port
  // ----------------------------------------------------------------
  localparam logic [7:0] CFG_DRIVE_LO = 8'h00;
  localparam logic [7:0] CFG_DRIVE_HI = 8'h01;
  localparam logic [7:0] CFG_GATE_MASK = 8'h02;
  localparam logic [7:0] CFG_SPREAD = 8'h03;
  localparam logic [7:0] CFG_SET0_BASE = 8'h10;
  localparam logic [7:0] CFG_SET1_BASE = 8'h20;
  localparam logic [7:0] SET_PLL_OFS = 8'h00;
  localparam logic [7:0] SET_DIV_OFS = 8'h04;
  localparam int SET_PLL_BYTES = 4;
  localparam int OUT_COUNT = 8;
  // ----------------------------------------------------------------
  // Drive strength codes and their typical edge times
  // ----------------------------------------------------------------
  localparam logic [1:0] DRV_LOW = 2'h0;
  localparam logic [1:0] DRV_MID_LOW = 2'h1;
  localparam logic [1:0] DRV_MID_HIGH = 2'h2;
  localparam logic [1:0] DRV_HIGH = 2'h3;
  localparam real DRV_LOW_EDGE_NS = 6.8;
  localparam real DRV_MID_LOW_EDGE_NS = 3.4;
  localparam real DRV_MID_HIGH_EDGE_NS = 2.0;
  localparam real DRV_HIGH_EDGE_NS = 1.0;
  // ----------------------------------------------------------------
  // APB registers
  // ----------------------------------------------------------------
  localparam logic [11:0] APB_CTRL_OFF = 12'h000;
  localparam logic [11:0] APB_STAT_OFF = 12'h004;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int CTRL_CLK3_SEL = 0;
  localparam int CTRL_CLK6_SPREAD = 1;
  localparam int CTRL_RST_EN = 2;
  localparam int CTRL_RST_CLEAN = 3;
  localparam int CTRL_PD_EN = 4;
  localparam int CTRL_GATE_EN = 5;
  localparam int CTRL_KEEP = 6;
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_AACK = 7'h04,
    ST_RX = 7'h08,
    ST_WACK = 7'h10,
    ST_TX = 7'h20,
    ST_MACK = 7'h40
  } icpac_state_e;
endpackage

// ==== testbench/icpac_bus_master.sv ====
// Two-wire bus master model that drives the serial configuration port.
`timescale 1ns/10ps
`default_nettype none
module icpac_bus_master #(
  parameter int HALF = 5
) (
  input wire logic pclk,
  input wire logic sda,
  output logic scl,
  output logic sda_pull
);
  initial begin
    scl = 1'h1;
    sda_pull = 1'h0;
  end
  task automatic wait_cycles(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // The serial clock stands high between frames; data moves only while it is low.
  // Each half period is HALF clock cycles, so one bit takes 80 ns.
  task automatic bit_cycle(input logic b, output logic r);
    sda_pull <= ~b;
    wait_cycles(HALF - 3);
    scl <= 1'h1;
    wait_cycles(2);
    r = sda;
    wait_cycles(HALF - 2);
    scl <= 1'h0;
    wait_cycles(3);
  endtask
  task automatic start();
    sda_pull <= 1'h0;
    wait_cycles(HALF - 3);
    scl <= 1'h1;
    wait_cycles(3);
    sda_pull <= 1'h1;
    wait_cycles(3);
    scl <= 1'h0;
    wait_cycles(3);
  endtask
  task automatic stop();
    sda_pull <= 1'h1;
    wait_cycles(HALF - 3);
    scl <= 1'h1;
    wait_cycles(3);
    sda_pull <= 1'h0;
    wait_cycles(HALF);
  endtask
  task automatic send(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_cycle(b[i], r);
    bit_cycle(1'h1, r);
    ack = ~r;
  endtask
  task automatic recv(input logic more, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'h1, r);
      b[i] = r;
    end
    bit_cycle(~more, r);
  endtask
endmodule // icpac_bus_master
`default_nettype wire

// ==== testbench/testbench.sv ====
// Self-checking bench for the serial configuration port and control block.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import icpac_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic scl, sda, sda_pull, sda_o, sda_oe, p3, prst, ppd, p6, a;
  logic [7:0] out_enable;
  logic out_hold_low, pll_off, spread_on, clk3_drive_en, clk6_drive_en, set_sel;
  logic [15:0] drive_strength;
  logic [63:0] div_value;
  logic div_load, pll_relock;
  int loads = 0;
  int relocks = 0;
  int miscompares = 0;
  int tests_run = 0;
  // Open-drain wire with a pull-up: any party pulling makes it low.
  assign sda = ~((sda_oe & ~sda_o) | sda_pull);
  always #4 pclk = ~pclk;
  icpac_config_port DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scl_pin(scl), .sda_pin_i(sda), .sda_pin_o(sda_o),
    .sda_pin_oe(sda_oe), .clock3_or_select_pin(p3), .aux_ref_or_restart_pin(prst),
    .power_down_or_gate_pin(ppd), .clock6_or_spread_toggle_pin(p6),
    .out_enable(out_enable), .out_hold_low(out_hold_low), .pll_off(pll_off),
    .spread_on(spread_on), .clk3_drive_en(clk3_drive_en), .clk6_drive_en(clk6_drive_en),
    .drive_strength(drive_strength), .set_sel(set_sel), .div_value(div_value),
    .div_load(div_load), .pll_relock(pll_relock));
  icpac_bus_master bm (.pclk(pclk), .sda(sda), .scl(scl), .sda_pull(sda_pull));
  // Strobes last one cycle, so they are counted as they occur.
  always @(posedge pclk) begin
    if (div_load === 1'h1) loads++;
    if (pll_relock === 1'h1) relocks++;
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic print_verdict();
    if (miscompares == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic [11:0] ad, input logic w, input logic [31:0] d);
    psel <= 1'h1;
    penable <= 1'h0;
    paddr <= ad;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  // Pin synchronisers and registered outputs need a few cycles to follow a pin.
  task automatic settle();
    repeat (8) @(posedge pclk);
  endtask
  task automatic ser_write(input logic [7:0] ptr, input logic [7:0] d[$]);
    bm.start();
    bm.send({BUS_SLAVE_ID, 1'h0}, a);
    check(a, 1'h1);
    bm.send(ptr, a);
    check(a, 1'h1);
    foreach (d[i]) begin
      bm.send(d[i], a);
      check(a, 1'h1);
    end
    bm.stop();
  endtask
  task automatic ser_read(input logic use_ptr, input logic [7:0] ptr, input logic [7:0] e[$]);
    logic [7:0] b;
    bm.start();
    if (use_ptr) begin
      bm.send({BUS_SLAVE_ID, 1'h0}, a);
      bm.send(ptr, a);
      bm.start();
    end
    bm.send({BUS_SLAVE_ID, 1'h1}, a);
    check(a, 1'h1);
    foreach (e[i]) begin
      bm.recv(i < e.size() - 1, b);
      check(b, e[i]);
    end
    bm.stop();
  endtask
  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'h0;
    presetn = 1'h0;
    {psel, penable, pwrite, p3, prst, p6} = 6'h00;
    ppd = 1'h1;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    apb(APB_STAT_OFF, 1'h0, 32'h0);
    check(rd, 32'h0);
    check(drive_strength, 16'h0);
    apb(12'h008, 1'h0, 32'h0);
    check(er, 1'h1);
    ser_write(8'hfe, '{8'h5a, 8'ha5, 8'h1b, 8'he4, 8'h01});
    ser_read(1'h1, 8'hfe, '{8'h5a, 8'ha5, 8'h1b});
    ser_read(1'h0, 8'h00, '{8'he4});
    apb(APB_STAT_OFF, 1'h0, 32'h0);
    check(rd[7:0], 8'h02);
    check(drive_strength, 16'he41b);
    bm.start();
    bm.send(8'ha4, a);
    check(a, 1'h0);
    bm.stop();
    ser_write(CFG_SET1_BASE + SET_DIV_OFS, '{8'h11});
    apb(APB_CTRL_OFF, 1'h1, 32'h01);
    check(clk3_drive_en, 1'h0);
    p3 <= 1'h1;
    settle();
    check(set_sel, 1'h1);
    check(div_value[7:0], 8'h11);
    p3 <= 1'h0;
    settle();
    check(div_value[7:0], 8'h00);
    check(loads, 2);
    check(relocks, 0);
    apb(APB_CTRL_OFF, 1'h1, 32'h02);
    p6 <= 1'h1;
    settle();
    check({clk6_drive_en, spread_on}, 2'h1);
    apb(APB_CTRL_OFF, 1'h1, 32'h20);
    ppd <= 1'h0;
    settle();
    check(out_enable[1:0], 2'h2);
    ppd <= 1'h1;
    settle();
    check(out_enable[1:0], 2'h3);
    apb(APB_CTRL_OFF, 1'h1, 32'h0c);
    prst <= 1'h1;
    settle();
    check({out_hold_low, out_enable}, 9'h100);
    prst <= 1'h0;
    settle();
    check({out_hold_low, out_enable}, 9'h0ff);
    check(drive_strength, 16'he41b);
    apb(APB_CTRL_OFF, 1'h1, 32'h50);
    ppd <= 1'h0;
    settle();
    check(pll_off, 1'h1);
    ppd <= 1'h1;
    settle();
    check({pll_off, drive_strength}, 17'h0e41b);
    apb(APB_CTRL_OFF, 1'h1, 32'h10);
    ppd <= 1'h0;
    settle();
    ppd <= 1'h1;
    settle();
    check(drive_strength, 16'h0);
    ser_write(8'h00, '{8'h77});
    apb(APB_CTRL_OFF, 1'h1, 32'h04);
    prst <= 1'h1;
    settle();
    prst <= 1'h0;
    settle();
    check(drive_strength, 16'h0);
    print_verdict();
  end
  initial begin
    #100000;
    miscompares++;
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
